// ===== core/bivl_pkg.sv
// Shared constants for the boot image verify and launch block.
// Assumes one 20 MHz clock and an I2C target port sampled on it.
package bivl_pkg;

    // Register addresses seen on the I2C target port
    localparam logic [7:0] BIVL_REG_STATUS = 8'h00;
    localparam logic [7:0] BIVL_REG_VERIFY = 8'hF3;
    localparam logic [7:0] BIVL_REG_LAUNCH = 8'hF4;

    // 7-bit target addresses, picked by the address-select pin
    localparam logic [6:0] BIVL_TGT_ADDR_LO = 7'h5A;
    localparam logic [6:0] BIVL_TGT_ADDR_HI = 7'h5B;

    // Status byte layout
    localparam logic [2:0] BIVL_STAT_VALID_BIT = 3'h4;
    localparam logic [2:0] BIVL_STAT_DONE_BIT = 3'h5;
    localparam logic [2:0] BIVL_STAT_RUN_BIT = 3'h7;
    localparam logic [7:0] BIVL_STAT_RESET = 8'h00;

    // Image layout in program flash
    localparam int BIVL_FLASH_AW = 16;
    localparam logic [15:0] BIVL_IMAGE_LAST = 16'h0FFF;
    localparam logic [7:0] BIVL_ERASED_BYTE = 8'hFF;

    // Bits per I2C byte, counted on SCL rising edges
    localparam logic [3:0] BIVL_BYTE_BITS = 4'h8;

    // I2C target states
    typedef enum logic [8:0] {
        BIVL_ST_IDLE = 9'h001,
        BIVL_ST_ADDR = 9'h002,
        BIVL_ST_AACK = 9'h004,
        BIVL_ST_REG = 9'h008,
        BIVL_ST_RACK = 9'h010,
        BIVL_ST_WDAT = 9'h020,
        BIVL_ST_WACK = 9'h040,
        BIVL_ST_RDAT = 9'h080,
        BIVL_ST_MACK = 9'h100
    } bivl_i2c_state_t;

    // Image checker states
    typedef enum logic [1:0] {
        BIVL_CK_IDLE = 2'h1,
        BIVL_CK_FETCH = 2'h2
    } bivl_chk_state_t;

endpackage : bivl_pkg

// ===== core/bivl_image_check.sv
// Image checker: walks program flash and tests the image checksum.
// Assumes a flash read port on the same clock answering with an ack pulse.
`timescale 1ns/10ps
`default_nettype none

module bivl_image_check (
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Control
    input wire logic start_in,
    output logic busy_out,
    output logic done_out,
    output logic ok_out,
    // Flash read port
    output logic flash_rd_out,
    output logic [bivl_pkg::BIVL_FLASH_AW-1:0] flash_addr_out,
    input wire logic [7:0] flash_data_in,
    input wire logic flash_ack_in
);
    import bivl_pkg::*;

    bivl_chk_state_t state_reg;
    logic [7:0] sum_reg;
    logic blank_reg;
    logic [7:0] sum_next;
    logic blank_next;

    // Running sum; an erased first byte marks a missing image
    assign sum_next = sum_reg + flash_data_in;
    assign blank_next = (flash_addr_out == '0) ?
                        (flash_data_in == BIVL_ERASED_BYTE) : blank_reg;

    // Walk every byte of the image once, one read at a time
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_reg <= BIVL_CK_IDLE;
            sum_reg <= '0;
            blank_reg <= 1'b0;
            flash_rd_out <= 1'b0;
            flash_addr_out <= '0;
            done_out <= 1'b0;
            ok_out <= 1'b0;
        end else begin
            done_out <= 1'b0;
            case (state_reg)
                BIVL_CK_IDLE: begin
                    if (start_in) begin
                        state_reg <= BIVL_CK_FETCH;
                        sum_reg <= '0;
                        blank_reg <= 1'b0;
                        flash_addr_out <= '0;
                        flash_rd_out <= 1'b1;
                    end
                end
                BIVL_CK_FETCH: begin
                    if (flash_ack_in) begin
                        sum_reg <= sum_next;
                        blank_reg <= blank_next;
                        if (flash_addr_out == BIVL_IMAGE_LAST) begin
                            // Whole image read: checksum must wrap to zero
                            state_reg <= BIVL_CK_IDLE;
                            flash_rd_out <= 1'b0;
                            done_out <= 1'b1;
                            ok_out <= (sum_next == '0) && !blank_next;
                        end else begin
                            flash_addr_out <= flash_addr_out + 1'b1;
                        end
                    end
                end
                default: begin
                    state_reg <= BIVL_CK_IDLE;
                    flash_rd_out <= 1'b0;
                end
            endcase
        end
    end

    assign busy_out = (state_reg != BIVL_CK_IDLE);

endmodule : bivl_image_check

`default_nettype wire

// ===== core/bivl_boot_ctrl.sv
// Boot command logic: I2C target, image check and application launch.
// Assumes open-drain SCL/SDA pins, flash read port and stored outcome.
`timescale 1ns/10ps
`default_nettype none

module bivl_boot_ctrl (
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // I2C target pins, SDA open drain
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    input wire logic addr_sel_in,
    // Program flash read port
    output logic flash_rd_out,
    output logic [bivl_pkg::BIVL_FLASH_AW-1:0] flash_addr_out,
    input wire logic [7:0] flash_data_in,
    input wire logic flash_ack_in,
    // Stored check outcome
    input wire logic stored_valid_in,
    output logic result_wr_out,
    output logic result_valid_out,
    // Mode
    output logic app_run_out
);
    import bivl_pkg::*;

    // Pin synchronisers plus one history stage for edges
    logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d, sel_s1, sel_s2;
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            {scl_s1, scl_s2, scl_d} <= 3'h7;
            {sda_s1, sda_s2, sda_d} <= 3'h7;
            {sel_s1, sel_s2} <= 2'h0;
        end else begin
            {scl_s1, scl_s2, scl_d} <= {scl_in, scl_s1, scl_s2};
            {sda_s1, sda_s2, sda_d} <= {sda_in, sda_s1, sda_s2};
            {sel_s1, sel_s2} <= {addr_sel_in, sel_s1};
        end
    end

    logic scl_rise, scl_fall, start_det, stop_det, fire;
    logic [6:0] tgt_addr;
    assign scl_rise = scl_s2 && !scl_d;
    assign scl_fall = !scl_s2 && scl_d;
    assign start_det = scl_s2 && scl_d && sda_d && !sda_s2;
    assign stop_det = scl_s2 && scl_d && !sda_d && sda_s2;
    // A selection is acted on at the stop or repeated start ending it
    assign fire = start_det || stop_det;
    assign tgt_addr = sel_s2 ? BIVL_TGT_ADDR_HI : BIVL_TGT_ADDR_LO;

    bivl_i2c_state_t st_reg;
    logic [3:0] cnt_reg;
    logic [7:0] shift_reg, ptr_reg, tx_reg, status_byte;
    logic rw_reg, nack_reg, pend_verify_reg, pend_launch_reg;
    logic done_reg, app_valid_reg, chk_go_reg, init_reg;
    logic chk_busy, chk_done, chk_ok;

    // Status byte; reserved bits read as zero
    always_comb begin
        status_byte = BIVL_STAT_RESET;
        status_byte[BIVL_STAT_DONE_BIT] = done_reg;
        status_byte[BIVL_STAT_VALID_BIT] = app_valid_reg;
        status_byte[BIVL_STAT_RUN_BIT] = app_run_out;
    end

    // I2C target: sample on SCL rise, drive SDA after SCL fall
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st_reg <= BIVL_ST_IDLE;
            cnt_reg <= '0;
            shift_reg <= '0;
            ptr_reg <= BIVL_REG_STATUS;
            tx_reg <= '0;
            rw_reg <= 1'b0;
            nack_reg <= 1'b0;
            sda_oe_out <= 1'b0;
        end else if (start_det) begin
            st_reg <= BIVL_ST_ADDR;
            cnt_reg <= '0;
            sda_oe_out <= 1'b0;
        end else if (stop_det) begin
            st_reg <= BIVL_ST_IDLE;
            sda_oe_out <= 1'b0;
        end else begin
            if (scl_rise) begin
                shift_reg <= {shift_reg[6:0], sda_s2};
                cnt_reg <= cnt_reg + 1'b1;
                nack_reg <= sda_s2;
            end
            if (scl_fall) begin
                case (st_reg)
                    BIVL_ST_ADDR: begin
                        if (cnt_reg == BIVL_BYTE_BITS) begin
                            cnt_reg <= '0;
                            // Other targets' traffic is left alone
                            if (shift_reg[7:1] == tgt_addr) begin
                                rw_reg <= shift_reg[0];
                                sda_oe_out <= 1'b1;
                                st_reg <= BIVL_ST_AACK;
                            end else begin
                                st_reg <= BIVL_ST_IDLE;
                            end
                        end
                    end
                    BIVL_ST_AACK: begin
                        cnt_reg <= '0;
                        if (rw_reg) begin
                            sda_oe_out <= !status_byte[7];
                            tx_reg <= (ptr_reg == BIVL_REG_STATUS) ?
                                      {status_byte[6:0], 1'b0} : '0;
                            st_reg <= BIVL_ST_RDAT;
                        end else begin
                            sda_oe_out <= 1'b0;
                            st_reg <= BIVL_ST_REG;
                        end
                    end
                    BIVL_ST_REG: begin
                        if (cnt_reg == BIVL_BYTE_BITS) begin
                            cnt_reg <= '0;
                            ptr_reg <= shift_reg;
                            sda_oe_out <= 1'b1;
                            st_reg <= BIVL_ST_RACK;
                        end
                    end
                    BIVL_ST_RACK, BIVL_ST_WACK: begin
                        cnt_reg <= '0;
                        sda_oe_out <= 1'b0;
                        st_reg <= BIVL_ST_WDAT;
                    end
                    BIVL_ST_WDAT: begin
                        // Data bytes are acknowledged and dropped
                        if (cnt_reg == BIVL_BYTE_BITS) begin
                            cnt_reg <= '0;
                            sda_oe_out <= 1'b1;
                            st_reg <= BIVL_ST_WACK;
                        end
                    end
                    BIVL_ST_RDAT: begin
                        if (cnt_reg == BIVL_BYTE_BITS) begin
                            cnt_reg <= '0;
                            sda_oe_out <= 1'b0;
                            st_reg <= BIVL_ST_MACK;
                        end else begin
                            sda_oe_out <= !tx_reg[7];
                            tx_reg <= {tx_reg[6:0], 1'b0};
                        end
                    end
                    BIVL_ST_MACK: begin
                        cnt_reg <= '0;
                        if (nack_reg) begin
                            st_reg <= BIVL_ST_IDLE;
                        end else begin
                            // Repeated reads return the live status
                            sda_oe_out <= !status_byte[7];
                            tx_reg <= (ptr_reg == BIVL_REG_STATUS) ?
                                      {status_byte[6:0], 1'b0} : '0;
                            st_reg <= BIVL_ST_RDAT;
                        end
                    end
                    default: begin
                        sda_oe_out <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Open drain: the pin is only ever pulled low
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
        end
    end

    // Command selection: the register byte after the address is the command
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pend_verify_reg <= 1'b0;
            pend_launch_reg <= 1'b0;
        end else if (fire) begin
            pend_verify_reg <= 1'b0;
            pend_launch_reg <= 1'b0;
        end else if (scl_fall && st_reg == BIVL_ST_REG &&
                     cnt_reg == BIVL_BYTE_BITS) begin
            pend_verify_reg <= (shift_reg == BIVL_REG_VERIFY);
            pend_launch_reg <= (shift_reg == BIVL_REG_LAUNCH);
        end
    end

    // Start the checker; a second request while busy is dropped
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            chk_go_reg <= 1'b0;
        end else begin
            chk_go_reg <= fire && pend_verify_reg && !app_run_out &&
                          !chk_busy && !chk_go_reg;
        end
    end

    bivl_image_check u_check (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .start_in(chk_go_reg),
        .busy_out(chk_busy),
        .done_out(chk_done),
        .ok_out(chk_ok),
        .flash_rd_out(flash_rd_out),
        .flash_addr_out(flash_addr_out),
        .flash_data_in(flash_data_in),
        .flash_ack_in(flash_ack_in)
    );

    // Image validity: stored outcome loaded after reset, then updated
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            init_reg <= 1'b0;
            app_valid_reg <= 1'b0;
            result_wr_out <= 1'b0;
            result_valid_out <= 1'b0;
        end else begin
            init_reg <= 1'b1;
            result_wr_out <= chk_done;
            if (!init_reg) begin
                app_valid_reg <= stored_valid_in;
            end else if (chk_done) begin
                app_valid_reg <= chk_ok;
                result_valid_out <= chk_ok;
            end
        end
    end

    // Completion flag: set wins, cleared only by launch or reset
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            done_reg <= 1'b0;
        end else if (chk_done) begin
            done_reg <= 1'b1;
        end else if (fire && pend_launch_reg && app_valid_reg) begin
            done_reg <= 1'b0;
        end
    end

    // Launch: leave boot mode only with a valid image
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            app_run_out <= 1'b0;
        end else if (fire && pend_launch_reg && app_valid_reg) begin
            app_run_out <= 1'b1;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    sequence s_launch_fire;
        fire && pend_launch_reg;
    endsequence

    sequence s_reg_byte(logic [7:0] code);
        scl_fall && st_reg == BIVL_ST_REG && cnt_reg == BIVL_BYTE_BITS &&
        shift_reg == code && !fire;
    endsequence

    // The pending flag carries the selection across any length of frame
    sequence s_verify_fire;
        fire && pend_verify_reg && !app_run_out && !chk_busy && !chk_go_reg;
    endsequence

    a_verify_select: assert property (
        s_reg_byte(BIVL_REG_VERIFY) |=> pend_verify_reg)
        else $error("check selection not captured");

    a_verify_start: assert property (
        s_verify_fire |=> chk_go_reg ##1 chk_busy)
        else $error("verify command did not start the check");

    a_result_store: assert property (
        chk_done |=> result_wr_out && result_valid_out == $past(chk_ok)
        && app_valid_reg == $past(chk_ok))
        else $error("check outcome not stored");

    a_init_load: assert property (
        !init_reg |=> app_valid_reg == $past(stored_valid_in))
        else $error("stored outcome not loaded at initialisation");

    a_done_flag: assert property (
        chk_done |=> status_byte[BIVL_STAT_DONE_BIT] && done_reg)
        else $error("completion flag not set after check");

    a_done_sticky: assert property (
        done_reg && !(fire && pend_launch_reg && app_valid_reg)
        |=> done_reg)
        else $error("completion flag cleared without launch");

    a_launch_select: assert property (
        s_reg_byte(BIVL_REG_LAUNCH) |=> pend_launch_reg)
        else $error("launch selection not captured");

    a_launch_valid: assert property (
        s_launch_fire ##0 app_valid_reg |=> app_run_out && !done_reg)
        else $error("valid image not launched");

    a_stay_boot: assert property (
        s_launch_fire ##0 !app_valid_reg && !app_run_out |=> !app_run_out)
        else $error("launched without a valid image");

    a_addr_filter: assert property (
        scl_fall && st_reg == BIVL_ST_ADDR && cnt_reg == BIVL_BYTE_BITS &&
        !fire && shift_reg[7:1] != tgt_addr |=> st_reg == BIVL_ST_IDLE
        && !sda_oe_out)
        else $error("foreign target address acknowledged");

endmodule : bivl_boot_ctrl

`default_nettype wire

// ===== tb/bivl_host_model.sv
// Host controller model: drives SCL and pulls SDA low as I2C bus master.
// Assumes the bench resolves a pulled-up SDA line and runs clk_in at 20 MHz.
`timescale 1ns/10ps
`default_nettype none

module bivl_host_model (
    // Timing reference
    input wire logic clk_in,
    // Bus lines
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_oe_out
);
    import bivl_pkg::*;

    // Quarter SCL period in clocks; half period stays above the 8 allowed
    localparam int QTR = 5;

    initial begin
        scl_out = 1'b1;
        sda_oe_out = 1'b0;
    end

    // Falling-edge waits keep every change away from the sampling edge
    task automatic hwait(input int n);
        repeat (n) @(negedge clk_in);
    endtask : hwait

    // START or repeated START: SDA falls while SCL is high
    task automatic bus_start();
        sda_oe_out = 1'b0;
        hwait(QTR);
        scl_out = 1'b1;
        hwait(2 * QTR);
        sda_oe_out = 1'b1;
        hwait(2 * QTR);
        scl_out = 1'b0;
        hwait(QTR);
    endtask : bus_start

    // STOP: SDA rises while SCL is high, leaving the bus released
    task automatic bus_stop();
        sda_oe_out = 1'b1;
        hwait(QTR);
        scl_out = 1'b1;
        hwait(2 * QTR);
        sda_oe_out = 1'b0;
        hwait(2 * QTR);
    endtask : bus_stop

    // One bit: data moves only while SCL is low, sampled mid high phase
    task automatic bus_bit(input logic b, output logic got);
        sda_oe_out = ~b;
        hwait(QTR);
        scl_out = 1'b1;
        hwait(QTR);
        got = sda_in;
        hwait(QTR);
        scl_out = 1'b0;
        hwait(QTR);
    endtask : bus_bit

    // Eight bits MSB first, then the acknowledge slot
    task automatic bus_byte(input logic [7:0] tx, input logic ack_bit,
                            output logic [7:0] rx, output logic ack);
        logic got;
        for (int i = 7; i >= 0; i--) begin
            bus_bit(tx[i], got);
            rx[i] = got;
        end
        bus_bit(ack_bit, got);
        ack = ~got;
    endtask : bus_byte

    // Register-address-only write, no data phase follows
    task automatic reg_write(input logic [6:0] tgt, input logic [7:0] ra,
                             output logic ok);
        logic [7:0] rx;
        logic a1;
        logic a2;
        bus_start();
        bus_byte({tgt, 1'b0}, 1'b1, rx, a1);
        a2 = 1'b0;
        if (a1) begin
            bus_byte(ra, 1'b1, rx, a2);
        end
        bus_stop();
        ok = a1 & a2;
    endtask : reg_write

    // Status read; the host NACKs the single byte it wants
    task automatic reg_read(input logic [6:0] tgt, output logic [7:0] st,
                            output logic ok);
        logic [7:0] rx;
        logic a1;
        logic a2;
        logic a3;
        logic dummy;
        bus_start();
        bus_byte({tgt, 1'b0}, 1'b1, rx, a1);
        bus_byte(BIVL_REG_STATUS, 1'b1, rx, a2);
        bus_start();
        bus_byte({tgt, 1'b1}, 1'b1, rx, a3);
        bus_byte(8'hFF, 1'b1, st, dummy);
        bus_stop();
        ok = a1 & a2 & a3;
    endtask : reg_read

endmodule : bivl_host_model

`default_nettype wire

// ===== tb/test_boot_image_verify_and_launch.sv
// Self-checking bench for the boot command logic with a flash model.
// Assumes the host model drives the bus and the bench owns flash and reset.
`timescale 1ns/10ps
`default_nettype none

module test_boot_image_verify_and_launch;
    import bivl_pkg::*;

    // Clock, reset, pins and flash model state
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic addr_sel = 1'b0;
    logic stored_valid = 1'b0;
    logic scl;
    logic host_oe;
    logic sda_out;
    logic sda_oe;
    wire logic sda_line;
    logic flash_rd;
    logic [15:0] flash_addr;
    logic [7:0] flash_data = 8'h00;
    logic flash_ack = 1'b0;
    logic bad_image = 1'b0;
    logic result_wr;
    logic result_valid;
    logic app_run;
    int flash_wait = 0;
    int flash_cnt = 0;
    int wr_pulses = 0;
    int cycles = 0;
    int miscompares = 0;
    int checked = 0;

    always #25 clk_in = ~clk_in;

    // Open-drain line: low when either party pulls, else the pull-up
    assign sda_line = ~((sda_oe & ~sda_out) | host_oe);

    bivl_host_model u_host (.clk_in(clk_in), .sda_in(sda_line),
        .scl_out(scl), .sda_oe_out(host_oe));

    bivl_boot_ctrl u_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe_out(sda_oe), .addr_sel_in(addr_sel),
        .flash_rd_out(flash_rd), .flash_addr_out(flash_addr),
        .flash_data_in(flash_data), .flash_ack_in(flash_ack),
        .stored_valid_in(stored_valid), .result_wr_out(result_wr),
        .result_valid_out(result_valid), .app_run_out(app_run));

    // Image sums to zero with a programmed first byte unless spoiled
    function automatic logic [7:0] img_byte(input logic [15:0] a);
        if (a == 16'h0000) return 8'h01;
        if (a == 16'h0001) return bad_image ? 8'h00 : 8'hFF;
        return 8'h00;
    endfunction : img_byte

    // Flash answers after flash_wait cycles; data flips off the ack cycle
    // so a stale byte can never be taken for a fresh one
    always @(negedge clk_in) begin
        if (flash_ack) begin
            flash_ack <= 1'b0;
            flash_data <= ~flash_data;
        end else if (flash_rd && flash_cnt >= flash_wait) begin
            flash_ack <= 1'b1;
            flash_data <= img_byte(flash_addr);
            flash_cnt <= 0;
        end else if (flash_rd) begin
            flash_cnt <= flash_cnt + 1;
        end
    end

    // Store-pulse counter and hang limit, well above the expected run
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (result_wr) wr_pulses <= wr_pulses + 1;
        if (cycles == 80000) begin
            miscompares++;
            test_done();
        end
    end

    task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_val

    task automatic test_done();
        $display("Checks %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done

    task automatic do_reset(input logic stored);
        @(negedge clk_in);
        sys_rst_in = 1'b1;
        stored_valid = stored;
        repeat (5) @(negedge clk_in);
        sys_rst_in = 1'b0;
        repeat (6) @(negedge clk_in);
    endtask : do_reset

    // Check time varies, so poll the flag with a bounded number of reads
    task automatic poll_done(input logic [6:0] tgt, output logic [7:0] st);
        logic ok;
        st = 8'h00;
        for (int i = 0; i < 40 && st[5] !== 1'b1; i++) begin
            u_host.reg_read(tgt, st, ok);
        end
    endtask : poll_done

    task automatic t_idle();
        logic [7:0] st;
        logic ok;
        do_reset(1'b0);
        check_val({4'h0, sda_out, app_run, result_valid, sda_oe}, 8'h00);
        u_host.reg_read(BIVL_TGT_ADDR_LO, st, ok);
        check_val({7'h00, ok}, 8'h01);
        check_val(st, 8'h00);
        $display("t_idle done");
    endtask : t_idle

    task automatic t_verify_bad();
        logic [7:0] st;
        logic ok;
        int base;
        bad_image = 1'b1;
        base = wr_pulses;
        u_host.reg_write(BIVL_TGT_ADDR_LO, BIVL_REG_VERIFY, ok);
        check_val({7'h00, ok}, 8'h01);
        poll_done(BIVL_TGT_ADDR_LO, st);
        check_val(st, 8'h20);
        check_val(flash_addr[15:8], BIVL_IMAGE_LAST[15:8]);
        check_val(flash_addr[7:0], BIVL_IMAGE_LAST[7:0]);
        check_val(8'(wr_pulses - base), 8'h01);
        check_val({7'h00, result_valid}, 8'h00);
        u_host.reg_write(BIVL_TGT_ADDR_LO, BIVL_REG_LAUNCH, ok);
        check_val({7'h00, app_run}, 8'h00);
        u_host.reg_read(BIVL_TGT_ADDR_LO, st, ok);
        check_val(st, 8'h20);
        $display("t_verify_bad done");
    endtask : t_verify_bad

    task automatic t_select();
        logic [7:0] st;
        logic ok;
        do_reset(1'b0);
        u_host.reg_write(BIVL_TGT_ADDR_HI, BIVL_REG_VERIFY, ok);
        check_val({7'h00, ok}, 8'h00);
        repeat (10) @(negedge clk_in);
        check_val({7'h00, flash_rd}, 8'h00);
        addr_sel = 1'b1;
        bad_image = 1'b0;
        flash_wait = 2;
        repeat (6) @(negedge clk_in);
        u_host.reg_write(BIVL_TGT_ADDR_HI, BIVL_REG_VERIFY, ok);
        check_val({7'h00, ok}, 8'h01);
        poll_done(BIVL_TGT_ADDR_HI, st);
        check_val(st, 8'h30);
        check_val({7'h00, result_valid}, 8'h01);
        $display("t_select done");
    endtask : t_select

    task automatic t_launch();
        logic [7:0] st;
        logic ok;
        u_host.reg_write(BIVL_TGT_ADDR_HI, BIVL_REG_LAUNCH, ok);
        check_val({6'h00, ok, app_run}, 8'h03);
        u_host.reg_read(BIVL_TGT_ADDR_HI, st, ok);
        check_val(st, 8'h90);
        u_host.reg_write(BIVL_TGT_ADDR_HI, BIVL_REG_VERIFY, ok);
        repeat (10) @(negedge clk_in);
        check_val({7'h00, flash_rd}, 8'h00);
        $display("t_launch done");
    endtask : t_launch

    task automatic t_stored();
        logic [7:0] st;
        logic ok;
        addr_sel = 1'b0;
        flash_wait = 0;
        do_reset(1'b1);
        u_host.reg_read(BIVL_TGT_ADDR_LO, st, ok);
        check_val(st, 8'h10);
        u_host.reg_write(BIVL_TGT_ADDR_LO, BIVL_REG_LAUNCH, ok);
        check_val({7'h00, app_run}, 8'h01);
        $display("t_stored done");
    endtask : t_stored

    initial begin
        t_idle();
        t_verify_bad();
        t_select();
        t_launch();
        t_stored();
        test_done();
    end

endmodule : test_boot_image_verify_and_launch

`default_nettype wire
